// *** logic/pbd_diag_top.sv ***
// packet buffer diagnostic access, loopback control and power-on reset top
//
// Operation
// - software can read the transmit and receive head and tail pointers through registers.
// - a software write to a pointer register loads that pointer; a write to the selected head pointer also steers later window accesses.
// - software reads and writes buffer contents through a window addressed by the head pointer that the window select picks.
// - mac loopback need not work at 10 Mb/s and is enabled only at the higher speeds.
// - the internal power-on reset is low while supplies are invalid and holds the phy in reset.
// - after supplies are valid the power-on reset stays low for at least the clock-start wait.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module pbd_diag_top
	import pbd_pkg::*;
#(
	parameter int unsigned ADDR_W   = 8,
	parameter int unsigned QWORDS   = WIN_QWORDS,
	parameter int unsigned WAIT_CYC = PHY_CLK_WAIT_CYC
)(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              supply_ok,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   por_n_o,
	output logic                   phy_rst_n_o,
	output logic                   mac_loopback_o,
	output logic [1:0]             rx_loopback_mode_field
);

	if (ADDR_W < 8 || QWORDS < 1 || QWORDS > 4096 * 2) begin : g_chk
		$error("unsupported address width or window depth");
	end

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [PTR_W-1:0]  tx_head;
		logic [PTR_W-1:0]  tx_tail;
		logic [PTR_W-1:0]  rx_head;
		logic [PTR_W-1:0]  rx_tail;
		logic [1:0]        lb_mode;
		logic              lb_req;
		logic              fdx;
		logic [1:0]        spd;
		logic              wsel;
		logic              mac_lb;
	} pbd_core_st_t;

	localparam pbd_core_st_t ST_RST = '{
		awready: 1'b1, wready: 1'b1, arready: 1'b1,
		tx_head: TX_PTR_RST, tx_tail: TX_PTR_RST,
		rx_head: RX_PTR_RST, rx_tail: RX_PTR_RST,
		lb_mode: LB_MODE_NORMAL, spd: SPD_10M, default: '0};

	pbd_core_st_t s_r;
	pbd_core_st_t s_nxt;

	pbd_por_if por ();

	logic [31:0]  win_mem [0:2*QWORDS-1];
	logic         wr_go;
	logic         ar_hs;
	logic [PTR_W:0] wr_idx;
	logic [PTR_W:0] rd_idx;
	logic         wr_idx_ok;
	logic         rd_idx_ok;
	logic         mem_we;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-lane merge of a pointer register
	function automatic logic [PTR_W-1:0] merge_ptr(input logic [PTR_W-1:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [15:0] w;
		w = {3'h0, old};
		if (be[0]) begin
			w[7:0] = d[7:0];
		end
		if (be[1]) begin
			w[15:8] = d[15:8];
		end
		return w[PTR_W-1:0];
	endfunction

	// dword index of the window: selected head pointer times two plus half select
	function automatic logic [PTR_W:0] win_index(input pbd_core_st_t st, input logic hi);
		return {(st.wsel ? st.tx_head : st.rx_head), hi};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// power-on reset sequencer

	pbd_por_seq #(
		.WAIT_CYC (WAIT_CYC)
	) u_por (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.supply_ok (supply_ok),
		.por       (por.seq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// window addressing
	assign wr_go     = s_r.aw_got && s_r.w_got && !s_r.bvalid;
	assign ar_hs     = s_axi_arvalid && s_r.arready;
	assign wr_idx    = win_index(s_r, s_r.aw_addr == ADDR_W'(OFS_WIN_HI));
	assign rd_idx    = win_index(s_r, s_axi_araddr == ADDR_W'(OFS_WIN_HI));
	assign wr_idx_ok = int'(wr_idx) < 2 * QWORDS;
	assign rd_idx_ok = int'(rd_idx) < 2 * QWORDS;
	assign mem_we    = wr_go && s_r.w_strb == 4'hF && wr_idx_ok
		&& (s_r.aw_addr == ADDR_W'(OFS_WIN_LO) || s_r.aw_addr == ADDR_W'(OFS_WIN_HI));

	// window memory write port
	always_ff @(posedge clk) begin
		if (mem_we) begin
			win_mem[wr_idx] <= s_r.w_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state: bus channels, register writes, reads, loopback
	always_comb begin
		s_nxt = s_r;
		// write address and data taken independently
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got  = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
			s_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got  = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
			s_nxt.wready = 1'b0;
		end
		// register write once both halves are held
		if (wr_go) begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = RESP_OKAY;
			unique case (s_r.aw_addr)
				ADDR_W'(OFS_TX_HEAD): s_nxt.tx_head = merge_ptr(s_r.tx_head, s_r.w_data, s_r.w_strb);
				ADDR_W'(OFS_TX_TAIL): s_nxt.tx_tail = merge_ptr(s_r.tx_tail, s_r.w_data, s_r.w_strb);
				ADDR_W'(OFS_RX_HEAD): s_nxt.rx_head = merge_ptr(s_r.rx_head, s_r.w_data, s_r.w_strb);
				ADDR_W'(OFS_RX_TAIL): s_nxt.rx_tail = merge_ptr(s_r.rx_tail, s_r.w_data, s_r.w_strb);
				ADDR_W'(OFS_CTRL): begin
					if (s_r.w_strb[0]) begin
						s_nxt.lb_mode = s_r.w_data[CTRL_LB_MODE_LSB +: 2];
						s_nxt.lb_req = s_r.w_data[CTRL_LB_REQ];
						s_nxt.fdx    = s_r.w_data[CTRL_FDX];
						s_nxt.spd    = s_r.w_data[CTRL_SPD_LSB +: 2];
						s_nxt.wsel   = s_r.w_data[CTRL_WSEL];
					end
				end
				ADDR_W'(OFS_STAT): s_nxt.bresp = RESP_OKAY;
				ADDR_W'(OFS_WIN_LO), ADDR_W'(OFS_WIN_HI): begin
					if (s_r.w_strb != 4'hF) begin
						s_nxt.bresp = RESP_SLVERR;
					end
				end
				default: s_nxt.bresp = RESP_DECERR;
			endcase
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid  = 1'b0;
			s_nxt.aw_got  = 1'b0;
			s_nxt.w_got   = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready  = 1'b1;
		end
		// read: answer on the same edge that takes the address
		if (ar_hs) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid  = 1'b1;
			s_nxt.rresp   = RESP_OKAY;
			s_nxt.rdata   = 32'h00000000;
			unique case (s_axi_araddr)
				ADDR_W'(OFS_TX_HEAD): s_nxt.rdata[PTR_W-1:0] = s_r.tx_head;
				ADDR_W'(OFS_TX_TAIL): s_nxt.rdata[PTR_W-1:0] = s_r.tx_tail;
				ADDR_W'(OFS_RX_HEAD): s_nxt.rdata[PTR_W-1:0] = s_r.rx_head;
				ADDR_W'(OFS_RX_TAIL): s_nxt.rdata[PTR_W-1:0] = s_r.rx_tail;
				ADDR_W'(OFS_CTRL): s_nxt.rdata[6:0] = {s_r.wsel, s_r.spd, s_r.fdx, s_r.lb_req, s_r.lb_mode};
				ADDR_W'(OFS_STAT): begin
					s_nxt.rdata[STAT_LB_ACT]   = s_r.mac_lb;
					s_nxt.rdata[STAT_POR_DONE] = por.por_n;
				end
				ADDR_W'(OFS_WIN_LO), ADDR_W'(OFS_WIN_HI): begin
					if (rd_idx_ok) begin
						s_nxt.rdata = win_mem[rd_idx];
					end
				end
				default: s_nxt.rresp = RESP_DECERR;
			endcase
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid  = 1'b0;
			s_nxt.arready = 1'b1;
		end
		// mac loopback only in full duplex above 10 Mb/s
		s_nxt.mac_lb = s_r.lb_req && s_r.fdx && s_r.spd != SPD_10M;
		// pointer, control and loopback state forced to reset values while power-on reset is low
		if (!por.por_n) begin
			s_nxt.tx_head = TX_PTR_RST;
			s_nxt.tx_tail = TX_PTR_RST;
			s_nxt.rx_head = RX_PTR_RST;
			s_nxt.rx_tail = RX_PTR_RST;
			s_nxt.lb_mode = LB_MODE_NORMAL;
			s_nxt.lb_req  = 1'b0;
			s_nxt.fdx     = 1'b0;
			s_nxt.spd     = SPD_10M;
			s_nxt.wsel    = 1'b0;
			s_nxt.mac_lb  = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from state flops
	assign s_axi_awready          = s_r.awready;
	assign s_axi_wready           = s_r.wready;
	assign s_axi_bvalid           = s_r.bvalid;
	assign s_axi_bresp            = s_r.bresp;
	assign s_axi_arready          = s_r.arready;
	assign s_axi_rvalid           = s_r.rvalid;
	assign s_axi_rdata            = s_r.rdata;
	assign s_axi_rresp            = s_r.rresp;
	assign mac_loopback_o         = s_r.mac_lb;
	assign rx_loopback_mode_field = s_r.lb_mode;
	assign por_n_o                = por.por_n;
	assign phy_rst_n_o            = por.phy_rst_n;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_full_wr(logic [ADDR_W-1:0] a);
		wr_go && s_r.aw_addr == a && s_r.w_strb == 4'hF && por.por_n;
	endsequence

	property p_ptr_rd;
		ar_hs && s_axi_araddr == ADDR_W'(OFS_TX_HEAD)
			|=> s_r.rvalid && s_r.rdata[PTR_W-1:0] == $past(s_r.tx_head) && s_r.rdata[31:PTR_W] == '0;
	endproperty
	a_ptr_rd: assert property (p_ptr_rd) else $error("head pointer read wrong");

	property p_ptr_wr;
		s_full_wr(ADDR_W'(OFS_TX_TAIL))
			|=> s_r.tx_tail == $past(s_r.w_data[PTR_W-1:0]) && s_r.bvalid && s_r.bresp == RESP_OKAY;
	endproperty
	a_ptr_wr: assert property (p_ptr_wr) else $error("tail pointer write lost");

	property p_ptr_free;
		s_full_wr(ADDR_W'(OFS_RX_HEAD)) |=> s_r.rx_head == $past(s_r.w_data[PTR_W-1:0]);
	endproperty
	a_ptr_free: assert property (p_ptr_free) else $error("pointer write not immediate");

	property p_win_wr;
		s_full_wr(ADDR_W'(OFS_WIN_LO)) ##0 wr_idx_ok |=> win_mem[$past(wr_idx)] == $past(s_r.w_data);
	endproperty
	a_win_wr: assert property (p_win_wr) else $error("window write missed");

	property p_narrow;
		wr_go && s_r.aw_addr == ADDR_W'(OFS_WIN_LO) && s_r.w_strb != 4'hF
			|-> !mem_we ##1 s_r.bresp == RESP_SLVERR;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow window write accepted");

	property p_lb_on;
		por.por_n && s_r.lb_req && s_r.fdx && s_r.spd != SPD_10M ##1 por.por_n |-> s_r.mac_lb;
	endproperty
	a_lb_on: assert property (p_lb_on) else $error("mac loopback not enabled");

	property p_lb_10m;
		s_r.spd == SPD_10M |=> !s_r.mac_lb;
	endproperty
	a_lb_10m: assert property (p_lb_10m) else $error("mac loopback at 10 Mb/s");

endmodule

`default_nettype wire

// *** logic/pbd_pkg.sv ***
// shared constants of the packet buffer diagnostic block
`default_nettype none

package pbd_pkg;

	// pointer and window geometry
	localparam int unsigned PTR_W      = 13;
	localparam int unsigned WIN_QWORDS = 5120;

	// register byte offsets
	localparam logic [7:0] OFS_TX_HEAD = 8'h00;
	localparam logic [7:0] OFS_TX_TAIL = 8'h04;
	localparam logic [7:0] OFS_RX_HEAD = 8'h08;
	localparam logic [7:0] OFS_RX_TAIL = 8'h0C;
	localparam logic [7:0] OFS_CTRL    = 8'h10;
	localparam logic [7:0] OFS_STAT    = 8'h14;
	localparam logic [7:0] OFS_WIN_LO  = 8'h18;
	localparam logic [7:0] OFS_WIN_HI  = 8'h1C;

	// pointer values after reset
	localparam logic [12:0] TX_PTR_RST = 13'h0600;
	localparam logic [12:0] RX_PTR_RST = 13'h0000;

	// control field positions
	localparam int unsigned CTRL_LB_MODE_LSB = 0;
	localparam int unsigned CTRL_LB_REQ  = 2;
	localparam int unsigned CTRL_FDX     = 3;
	localparam int unsigned CTRL_SPD_LSB = 4;
	localparam int unsigned CTRL_WSEL    = 6;

	// status field positions
	localparam int unsigned STAT_LB_ACT   = 0;
	localparam int unsigned STAT_POR_DONE = 1;

	// speed and loopback encodings
	localparam logic [1:0] SPD_10M    = 2'h0;
	localparam logic [1:0] LB_MODE_NORMAL = 2'h0;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// clock and power-on timing
	localparam int unsigned CLK_PERIOD_NS    = 20;
	localparam int unsigned PHY_CLK_WAIT_NS  = 1000;
	localparam int unsigned PHY_CLK_WAIT_CYC = (PHY_CLK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// *** logic/pbd_por_if.sv ***
// power-on reset carrier between sequencer and core
`timescale 1ns/100ps
`default_nettype none

interface pbd_por_if;
	logic por_n;
	logic phy_rst_n;
	modport seq (output por_n, output phy_rst_n);
	modport core (input por_n, input phy_rst_n);
endinterface

`default_nettype wire

// *** logic/pbd_por_seq.sv ***
// internal power-on reset sequencer holding mac and phy in reset
`timescale 1ns/100ps
`default_nettype none

module pbd_por_seq
	import pbd_pkg::*;
#(
	parameter int unsigned WAIT_CYC = PHY_CLK_WAIT_CYC
)(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic supply_ok,
	pbd_por_if.seq    por
);

	if (WAIT_CYC < 1 || WAIT_CYC > 4096) begin : g_chk
		$error("wait count out of range");
	end

	localparam logic [12:0] CNT_MAX = 13'(WAIT_CYC);

	typedef struct packed {
		logic [1:0]  sync;
		logic [12:0] cnt;
		logic        por_n;
	} pbd_por_st_t;

	pbd_por_st_t s_r;
	pbd_por_st_t s_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// next state: low while supply invalid, then count the clock-start wait
	always_comb begin
		s_nxt      = s_r;
		s_nxt.sync = {s_r.sync[0], supply_ok};
		if (!s_r.sync[1]) begin
			s_nxt.cnt   = 13'h0000;
			s_nxt.por_n = 1'b0;
		end else if (s_r.cnt != CNT_MAX) begin
			s_nxt.cnt = s_r.cnt + 13'h0001;
		end else begin
			s_nxt.por_n = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// phy reset follows the internal power-on reset
	assign por.por_n     = s_r.por_n;
	assign por.phy_rst_n = s_r.por_n;

	////////////////////////////////////////////////////////////////////////////////
	// helper: consecutive cycles with valid supply
	logic [13:0] hlp_ok_cnt;
	always_ff @(posedge clk) begin
		if (sys_rst || !s_r.sync[1]) begin
			hlp_ok_cnt <= 14'h0000;
		end else if (hlp_ok_cnt != 14'h3FFF) begin
			hlp_ok_cnt <= hlp_ok_cnt + 14'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_supply_bad;
		!s_r.sync[1];
	endsequence

	property p_hold_low;
		s_supply_bad |=> !por.por_n && !por.phy_rst_n;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("reset not held while supply bad");

	property p_min_wait;
		$rose(por.por_n) |-> int'(hlp_ok_cnt) >= WAIT_CYC;
	endproperty
	a_min_wait: assert property (p_min_wait) else $error("reset released too early");

endmodule

`default_nettype wire

// *** tb/test_packet_buffer_diag_loopback.sv ***
// self-checking bench of the packet buffer diagnostic block
`timescale 1ns/100ps
`default_nettype none

module test_packet_buffer_diag_loopback
	import pbd_pkg::*;
;
	localparam int unsigned WT = 4;
	localparam int unsigned QW = 5120;
	logic        clk, sys_rst, supply_ok;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp, mode;
	logic        por_n, phy_n, mac_lb;
	int          n_mismatch, total_checks;
	logic [12:0] m_ptr [4];
	logic [31:0] m_mem [int];
	logic        m_wsel;

	pbd_diag_top #(.ADDR_W(8), .QWORDS(QW), .WAIT_CYC(WT)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .supply_ok(supply_ok),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.por_n_o(por_n), .phy_rst_n_o(phy_n), .mac_loopback_o(mac_lb),
		.rx_loopback_mode_field(mode)
	);

	////////////////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#400000;
		n_mismatch++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, verdict and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// write: offer address and data together, wait for the response
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic [1:0] r;
		r = 2'h1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// wait for the response; only the watchdog ends a hang
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		chk({30'h0, r}, {30'h0, er});
	endtask

	// read: compare data and response with the model
	task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		d = 32'hDEAD_BEEF;
		r = 2'h1;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		// wait for the read data; only the watchdog ends a hang
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		chk(d, ed);
		chk({30'h0, r}, {30'h0, er});
	endtask

	// pointer write into design and model
	task automatic setp(input int k, input logic [12:0] v);
		wr(8'(k * 4), {19'h0, v}, 4'hF, RESP_OKAY);
		m_ptr[k] = v;
		rdc(8'(k * 4), {19'h0, v}, RESP_OKAY);
	endtask

	function automatic int widx(input logic hi);
		return (m_wsel ? int'(m_ptr[0]) : int'(m_ptr[2])) * 2 + int'(hi);
	endfunction

	task automatic win_wr(input logic hi, input logic [31:0] d);
		wr(hi ? OFS_WIN_HI : OFS_WIN_LO, d, 4'hF, RESP_OKAY);
		if (widx(hi) < 2 * QW) m_mem[widx(hi)] = d;
	endtask

	task automatic win_rd(input logic hi);
		rdc(hi ? OFS_WIN_HI : OFS_WIN_LO, m_mem.exists(widx(hi)) ? m_mem[widx(hi)] : 32'h0, RESP_OKAY);
	endtask

	task automatic set_ctrl(input logic ws, input logic [1:0] sp, input logic fd, input logic rq, input logic [1:0] md);
		wr(OFS_CTRL, {25'h0, ws, sp, fd, rq, md}, 4'hF, RESP_OKAY);
		m_wsel = ws;
		repeat (2) @(posedge clk);
		chk({31'h0, mac_lb}, {31'h0, rq & fd & (sp != SPD_10M)});
		chk({30'h0, mode}, {30'h0, md});
		rdc(OFS_STAT, {30'h0, 1'b1, rq & fd & (sp != SPD_10M)}, RESP_OKAY);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		int n;
		logic [12:0] h1, h2;
		logic [31:0] d;
		sys_rst = 1'b1;
		supply_ok = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		n_mismatch = 0;
		total_checks = 0;
		m_wsel = 1'b0;
		void'($urandom(24));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		// supplies invalid: both resets held, pointer writes discarded
		wr(OFS_TX_HEAD, 32'h0000_0123, 4'hF, RESP_OKAY);
		chk({30'h0, por_n, phy_n}, 32'h0);
		supply_ok <= 1'b1;
		for (n = 0; n < 100 && por_n !== 1'b1; n++) @(posedge clk);
		chk({31'h0, n >= WT && n <= WT + 4}, 32'h1);
		@(posedge clk);
		chk({31'h0, phy_n}, {31'h0, por_n});
		for (int k = 0; k < 4; k++) begin
			m_ptr[k] = (k < 2) ? TX_PTR_RST : RX_PTR_RST;
			rdc(8'(k * 4), {19'h0, m_ptr[k]}, RESP_OKAY);
		end
		// random pointers, tail below head accepted unchecked
		for (int k = 0; k < 4; k++) setp(k, 13'($urandom));
		// window through receive head, then transmit head on shared memory
		set_ctrl(1'b0, 2'h1, 1'b1, 1'b0, LB_MODE_NORMAL);
		h1 = 13'($urandom_range(QW - 1));
		h2 = 13'((h1 + 1) % QW);
		setp(2, h1);
		win_wr(1'b0, $urandom);
		win_wr(1'b1, $urandom);
		setp(2, h2);
		win_wr(1'b0, $urandom);
		setp(2, h1);
		win_rd(1'b0);
		win_rd(1'b1);
		set_ctrl(1'b1, 2'h2, 1'b1, 1'b0, LB_MODE_NORMAL);
		setp(0, h2);
		win_rd(1'b0);
		// narrow window write refused and location unchanged
		d = $urandom;
		wr(OFS_WIN_LO, d, 4'h3, RESP_SLVERR);
		win_rd(1'b0);
		// pointer beyond the buffer: write dropped, read zero
		setp(0, 13'h1FFF);
		win_wr(1'b1, $urandom);
		win_rd(1'b1);
		// unmapped offsets
		rdc(8'h20, 32'h0, RESP_DECERR);
		wr(8'h24, 32'h0, 4'hF, RESP_DECERR);
		// every speed, duplex and mode with loopback asked for
		for (int i = 0; i < 8; i++) begin
			set_ctrl(1'b0, 2'(i >> 1), i[0], 1'b1, 2'(i));
		end
		// supplies fail: both resets fall within five edges
		supply_ok <= 1'b0;
		repeat (5) @(posedge clk);
		chk({29'h0, por_n, phy_n, mac_lb}, 32'h0);
		stop_test();
	end
endmodule

`default_nettype wire
